// ---- dv/fsw_flash_model.sv ----
// Behavioural program flash array answering the controller's requests
`timescale 1ns/1ps
module fsw_flash_model
    import fsw_pkg::*;
(
    input wire logic core_clk_i,
    input wire fsw_flash_req_t req_i,
    input wire logic [447:0] wdata_i,
    output logic [13:0] rdata_o = 14'h0000,
    output logic done_o = 1'b0
);
    logic [13:0] mem [32768];
    int cnt = 0;
    // Never written words read back the low 14 bits of their address
    initial begin
        for (int i = 0; i < 32768; i++) begin
            mem[i] = 14'(i);
        end
    end
    function automatic logic [13:0] rdw(input int a);
        return mem[a];
    endfunction : rdw
    always @(posedge core_clk_i) begin
        int r;
        done_o <= 1'b0;
        // Stale data is not held past its one valid cycle
        rdata_o <= ~rdata_o;
        if (req_i.rd) begin
            rdata_o <= rdw(int'(req_i.addr));
        end
        if (req_i.erase || req_i.prog) begin
            for (int i = 0; i < 32; i++) begin
                r = int'({req_i.addr[14:5], 5'(i)});
                if (req_i.erase) begin
                    mem[r] = FSW_BLANK;
                end else begin
                    mem[r] = rdw(r) & wdata_i[i*14 +: 14];
                end
            end
            cnt <= $urandom_range(1, 8);
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
            done_o <= (cnt == 1);
        end
    end
endmodule : fsw_flash_model

// ---- dv/test_fsw_ctrl.sv ----
// Self-checking bench of the flash self-write controller
`timescale 1ns/1ps
module test_fsw_ctrl
    import fsw_pkg::*;
;
    logic core_clk_i = 0, reset_n_i = 0, reg_wr_i = 0, reg_rd_i = 0;
    logic seq_disturb_i = 0, fetch_req_i = 0;
    logic [3:0] reg_addr_i = 4'h0;
    logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o;
    logic [6:0] protect_top_i = 7'h00;
    logic [14:0] fetch_addr_i = 15'h0000, a;
    logic cpu_stall_o, done_irq_o, flash_done_i, fetch_valid_o;
    logic [13:0] flash_rdata_i, d, n_ops = 14'h0000, fetch_word_o;
    logic [447:0] flash_wdata_o;
    fsw_flash_req_t flash_req_o;
    int n_mismatch = 0, checks = 0;
    fsw_ctrl u_fsw_ctrl (
        .core_clk_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .seq_disturb_i, .protect_top_i,
        .fetch_req_i, .fetch_addr_i, .fetch_valid_o, .fetch_word_o,
        .cpu_stall_o, .done_irq_o, .flash_req_o, .flash_wdata_o,
        .flash_rdata_i, .flash_done_i
    );
    fsw_flash_model u_fsw_flash_model (.core_clk_i, .req_i(flash_req_o),
        .wdata_i(flash_wdata_o), .rdata_o(flash_rdata_i),
        .done_o(flash_done_i));
    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) begin
        if (flash_req_o.erase || flash_req_o.prog) begin
            n_ops <= n_ops + 14'h0001;
        end
    end
    task automatic test_done();
        if (n_mismatch == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic give_up();
        n_mismatch++;
        $display("wrong value at %0t: wait timed out", $time);
        test_done();
    endtask : give_up
    // Words never written read back the low 14 bits of their address
    task automatic fetch(input logic [14:0] ad, input logic [13:0] e);
        int n;
        n = 0;
        repeat (4) @(posedge core_clk_i);
        fetch_req_i <= 1'b1;
        fetch_addr_i <= ad;
        @(posedge core_clk_i);
        #1;
        while (fetch_valid_o !== 1'b1 && n < 10) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        if (n == 10) begin
            give_up();
        end
        cmp(fetch_word_o, e);
        @(posedge core_clk_i);
        fetch_req_i <= 1'b0;
    endtask : fetch
    task automatic cmp(input logic [13:0] got, input logic [13:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp
    task automatic wr(input logic [3:0] ad, input logic [7:0] dt);
        @(posedge core_clk_i);
        reg_addr_i <= ad;
        reg_wdata_i <= dt;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] ad, input logic [7:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= ad;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1;
        cmp({6'h00, reg_rdata_o}, {6'h00, e});
    endtask : rd
    // Bounded wait for the stall to drop
    task automatic idle();
        int n;
        n = 0;
        repeat (3) @(posedge core_clk_i);
        #1;
        while (cpu_stall_o !== 1'b0 && n < 50) begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        if (n == 50) begin
            give_up();
        end
    endtask : idle
    // The key sequence runs undisturbed unless bad is asked for
    task automatic unlock(input logic [7:0] ctl, input logic bad);
        wr(FSW_OFS_KEY, FSW_KEY1);
        if (bad) begin
            seq_disturb_i <= 1'b1;
            @(posedge core_clk_i);
            seq_disturb_i <= 1'b0;
            rd(FSW_OFS_CTL, 8'h2C);
        end
        wr(FSW_OFS_KEY, FSW_KEY2);
        wr(FSW_OFS_CTL, ctl);
        idle();
    endtask : unlock
    initial begin
        a = 15'($urandom(90961));
        a = {2'b01, 13'($urandom())};
        d = 14'($urandom());
        repeat (6) @(posedge core_clk_i);
        reset_n_i <= 1'b1;
        protect_top_i <= 7'h10;
        rd(FSW_OFS_CTL, 8'h00);
        rd(4'hA, 8'h00);
        rd(FSW_OFS_KEY, 8'h00);
        wr(FSW_OFS_ADRL, a[7:0]);
        wr(FSW_OFS_ADRH, {1'b0, a[14:8]});
        wr(FSW_OFS_CTL, 8'h01);
        idle();
        rd(FSW_OFS_DATL, a[7:0]);
        rd(FSW_OFS_DATH, {2'b00, a[13:8]});
        rd(FSW_OFS_CTL, 8'h00);
        unlock(8'h12, 1'b0);
        cmp(n_ops, 14'h0000);
        wr(FSW_OFS_CTL, 8'h14);
        unlock(8'h16, 1'b0);
        rd(FSW_OFS_CTL, 8'h14);
        rd(FSW_OFS_IRQ, 8'h01);
        cmp({13'h0000, done_irq_o}, 14'h0000);
        wr(FSW_OFS_IRQ, 8'h03);
        repeat (2) @(posedge core_clk_i);
        #1;
        cmp({13'h0000, done_irq_o}, 14'h0001);
        wr(FSW_OFS_IRQ, 8'h00);
        wr(FSW_OFS_CTL, 8'h01);
        idle();
        rd(FSW_OFS_DATL, 8'hFF);
        rd(FSW_OFS_DATH, 8'h3F);
        wr(FSW_OFS_DATL, d[7:0]);
        wr(FSW_OFS_DATH, {2'b00, d[13:8]});
        wr(FSW_OFS_CTL, 8'h24);
        unlock(8'h26, 1'b0);
        cmp(flash_wdata_o[a[4:0]*14 +: 14], d);
        cmp(n_ops, 14'h0001);
        wr(FSW_OFS_ADRL, a[7:0] ^ 8'h01);
        unlock(8'h26, 1'b1);
        rd(FSW_OFS_CTL, 8'h24);
        cmp(flash_wdata_o[(a[4:0]^5'h01)*14 +: 14], FSW_BLANK);
        wr(FSW_OFS_ADRL, a[7:0]);
        wr(FSW_OFS_CTL, 8'h04);
        unlock(8'h06, 1'b0);
        cmp(n_ops, 14'h0002);
        cmp(14'(&flash_wdata_o), 14'h0001);
        rd(FSW_OFS_CTL, 8'h04);
        wr(FSW_OFS_CTL, 8'h01);
        idle();
        rd(FSW_OFS_DATL, d[7:0]);
        rd(FSW_OFS_DATH, {2'b00, d[13:8]});
        wr(FSW_OFS_PTRL, a[7:0]);
        wr(FSW_OFS_PTRH, {1'b1, a[14:8]});
        idle();
        rd(FSW_OFS_IND, d[7:0]);
        wr(FSW_OFS_PTRH, {1'b0, a[14:8]});
        idle();
        rd(FSW_OFS_IND, 8'h00);
        wr(FSW_OFS_ADRH, 8'h05);
        wr(FSW_OFS_CTL, 8'h14);
        unlock(8'h16, 1'b0);
        rd(FSW_OFS_CTL, 8'h1C);
        cmp(n_ops, 14'h0002);
        fetch(15'h0020, 14'h0020);
        fetch(15'h0010 | 15'($urandom_range(0, 15)), FSW_NOP);
        test_done();
    end
endmodule : test_fsw_ctrl

// ---- src/fsw_ctrl.sv ----
// Flash self-write controller: register access to the program flash
// Function
// - Program flash is rows of 32 words of 14 bits; row erase only.
// - Erase sets a row to ones; program clears bits; reads one word.
// - Program or erase stalls the CPU until the array timer ends it.
// - A fetched word that is no valid instruction executes as NOP.
// - Indirect read hits flash when pointer bit 7 set; self-pointer reads 0.
// - Indirect read takes two cycles, stalls the CPU, delivers one byte.
// - Indirect stores to program flash have no effect.
// - Register writes or erases to protected areas are blocked.
// - Read: choose region, load address, set read bit; hardware clears it.
// - Read word lands in data pair as the two-cycle read stall ends and is held there.
// - Unlock is 55h, AAh to key register, then write bit, consecutively.
// - Erase, latch transfer and config writes need a full unlock.
// - A disturbed unlock performs neither latch load nor program nor erase.
// - Erase: region, address, erase and enable bits, unlock; no auto erase.
// - Erase of a protected address clears the write bit, memory untouched.
// - Finished operation sets done flag; interrupt only when enabled.
// - Row erase leaves write latches and enable bit unchanged.
// - Upper ten address bits pick the row, low five bits the latch.
// - Finished program resets every write latch to 3FFFh.
// - Latch-only mode loads one latch; otherwise all latches program the row.
// - Write or erase at a protected location sets the error flag.
// - Broken unlock sets the error flag; software clears or sets it.
`timescale 1ns/1ps
module fsw_ctrl
    import fsw_pkg::*;
#(
    parameter int ROW_WORDS = FSW_ROW_WORDS,
    parameter int WORD_W = FSW_WORD_W
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    input wire logic seq_disturb_i,
    input wire logic [6:0] protect_top_i,
    input wire logic fetch_req_i,
    input wire logic [14:0] fetch_addr_i,
    output logic fetch_valid_o,
    output logic [13:0] fetch_word_o,
    output logic cpu_stall_o,
    output logic done_irq_o,
    output fsw_flash_req_t flash_req_o,
    output logic [ROW_WORDS*WORD_W-1:0] flash_wdata_o,
    input wire logic [13:0] flash_rdata_i,
    input wire logic flash_done_i
);

    if (ROW_WORDS != FSW_ROW_WORDS || WORD_W != FSW_WORD_W) begin : g_chk
        $error("fsw_ctrl: address split serves 32 words of 14 bits only");
    end

    typedef enum logic [1:0] {S_IDLE, S_REQ, S_CAP, S_OP} fsw_state_t;
    typedef enum logic [1:0] {K_NVM, K_IND, K_FETCH, K_OP} fsw_kind_t;

    fsw_state_t st_reg;
    fsw_state_t st_next;
    fsw_kind_t kind_reg;
    fsw_kind_t kind_next;
    fsw_flash_req_t freq_next;
    logic [7:0] adrl_reg, adrh_reg, datl_reg;
    logic [5:0] dath_reg;
    logic [7:0] ptrl_reg, ptrh_reg, ind_reg;
    logic [6:0] ctl_reg, ctl_next;
    logic done_reg, ie_reg, op_erase_reg, ind_pend_reg;
    logic [7:0] rd_mux;
    logic unl_ok, unl_broken;

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire wr_adrl = reg_wr_i && reg_addr_i == FSW_OFS_ADRL;
    wire wr_adrh = reg_wr_i && reg_addr_i == FSW_OFS_ADRH;
    wire wr_datl = reg_wr_i && reg_addr_i == FSW_OFS_DATL;
    wire wr_dath = reg_wr_i && reg_addr_i == FSW_OFS_DATH;
    wire wr_ctl = reg_wr_i && reg_addr_i == FSW_OFS_CTL;
    wire wr_key = reg_wr_i && reg_addr_i == FSW_OFS_KEY;
    wire wr_irq = reg_wr_i && reg_addr_i == FSW_OFS_IRQ;
    wire wr_ptrl = reg_wr_i && reg_addr_i == FSW_OFS_PTRL;
    wire wr_ptrh = reg_wr_i && reg_addr_i == FSW_OFS_PTRH;
    // Stores to the indirect register decode to nothing
    wire wr_ind = reg_wr_i && reg_addr_i == FSW_OFS_IND;

    // ------------------------------------------------------------
    // Address checks
    // ------------------------------------------------------------
    wire [14:0] nvm_addr = {adrh_reg[6:0], adrl_reg};
    wire cfg = ctl_reg[FSW_B_REGS];
    wire cfg_rdok = nvm_addr <= FSW_UID_HI
        || (nvm_addr >= FSW_DID_LO && nvm_addr <= FSW_CFG_HI)
        || (nvm_addr >= FSW_DIA_LO && nvm_addr <= FSW_DIA_HI);
    wire cfg_wrok = nvm_addr <= FSW_UID_HI
        || (nvm_addr >= FSW_CFG_LO && nvm_addr <= FSW_CFG_HI);
    // Protection boundary comes from configuration, not from software
    wire wr_prot = cfg ? !cfg_wrok
        : nvm_addr[14:8] < protect_top_i;
    wire nvm_rdok = !cfg || cfg_rdok;
    wire [13:0] rd_word = nvm_rdok ? flash_rdata_i : 14'h0000;

    // ------------------------------------------------------------
    // Operation selection
    // ------------------------------------------------------------
    wire idle = st_reg == S_IDLE;
    wire free = ctl_reg[FSW_B_FREE];
    wire latch_only_mode = !free && ctl_reg[FSW_B_LATCH_ONLY_MODE];
    wire wr_go = idle && ctl_reg[FSW_B_WR];
    wire lat_go = wr_go && latch_only_mode;
    wire wr_blk = wr_go && !latch_only_mode && wr_prot;
    wire op_go = wr_go && !latch_only_mode && !wr_prot;
    wire rd_go = idle && !ctl_reg[FSW_B_WR] && ctl_reg[FSW_B_RD];
    wire ind_go = idle && !wr_go && !rd_go && ind_pend_reg;
    wire fetch_go = idle && !wr_go && !rd_go && !ind_pend_reg
        && fetch_req_i;
    wire op_fin = st_reg == S_OP && flash_done_i;
    wire cap = st_reg == S_CAP;
    wire cap_nvm = cap && kind_reg == K_NVM;
    wire cap_ind = cap && kind_reg == K_IND;
    wire cap_fet = cap && kind_reg == K_FETCH;
    wire illegal = (flash_rdata_i & FSW_RSVD_MASK) == FSW_RSVD_VAL;
    wire ptr_pfm = ptrh_reg[FSW_B_PFM];
    wire hw_err = wr_blk || unl_broken;
    wire start_wr = wr_ctl && reg_wdata_i[FSW_B_WR];

    fsw_unlock u_unlock (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .key_wr_i(wr_key),
        .key_data_i(reg_wdata_i),
        .any_acc_i(reg_wr_i || reg_rd_i),
        .start_i(start_wr),
        .disturb_i(seq_disturb_i),
        .ok_o(unl_ok),
        .broken_o(unl_broken)
    );

    // ------------------------------------------------------------
    // Control register next value
    // ------------------------------------------------------------
    wire [6:0] ctl_base = wr_ctl
        ? ((reg_wdata_i[6:0] & FSW_CTL_SOFT) | (ctl_reg & ~FSW_CTL_SOFT))
        : ctl_reg;

    // Hardware set beats the clear in the same cycle
    always_comb begin
        ctl_next = ctl_base;
        ctl_next[FSW_B_RD] = (wr_ctl && reg_wdata_i[FSW_B_RD])
            || (ctl_reg[FSW_B_RD] && !cap_nvm);
        ctl_next[FSW_B_WR] = (unl_ok && ctl_reg[FSW_B_EN])
            || (ctl_reg[FSW_B_WR] && !(lat_go || wr_blk || op_fin));
        ctl_next[FSW_B_ERR] = hw_err || (wr_ctl ? reg_wdata_i[FSW_B_ERR]
            : ctl_reg[FSW_B_ERR]);
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        kind_next = kind_reg;
        unique case (st_reg)
            S_IDLE: begin
                if (op_go) begin
                    st_next = S_OP;
                    kind_next = K_OP;
                end else if (rd_go) begin
                    st_next = S_REQ;
                    kind_next = K_NVM;
                end else if (ind_go) begin
                    st_next = S_REQ;
                    kind_next = K_IND;
                end else if (fetch_go) begin
                    st_next = S_REQ;
                    kind_next = K_FETCH;
                end
            end
            S_REQ: st_next = S_CAP;
            S_CAP: st_next = S_IDLE;
            S_OP: begin
                if (flash_done_i) begin
                    st_next = S_IDLE;
                end
            end
        endcase
    end

    // Row operations go out row-aligned; reads carry the full address
    always_comb begin
        freq_next.rd = rd_go || (ind_go && ptr_pfm) || fetch_go;
        freq_next.erase = op_go && free;
        freq_next.prog = op_go && !free;
        freq_next.cfg = (rd_go || op_go) && cfg;
        if (op_go) begin
            freq_next.addr = {nvm_addr[14:5], 5'h00};
        end else if (rd_go) begin
            freq_next.addr = nvm_addr;
        end else if (ind_go) begin
            freq_next.addr = {ptrh_reg[6:0], ptrl_reg};
        end else begin
            freq_next.addr = fetch_addr_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= S_IDLE;
            kind_reg <= K_NVM;
            flash_req_o <= '0;
            cpu_stall_o <= 1'b0;
            op_erase_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            kind_reg <= kind_next;
            flash_req_o <= freq_next;
            cpu_stall_o <= st_next != S_IDLE && kind_next != K_FETCH;
            if (op_go) begin
                op_erase_reg <= free;
            end
        end
    end

    // ------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            adrl_reg <= FSW_BYTE_RST;
            adrh_reg <= FSW_BYTE_RST;
            ptrl_reg <= FSW_BYTE_RST;
            ptrh_reg <= FSW_BYTE_RST;
            ctl_reg <= FSW_CTL_RST;
            ie_reg <= 1'b0;
            done_reg <= 1'b0;
            ind_pend_reg <= 1'b0;
        end else begin
            if (wr_adrl) adrl_reg <= reg_wdata_i;
            if (wr_adrh) adrh_reg <= {1'b0, reg_wdata_i[6:0]};
            if (wr_ptrl) ptrl_reg <= reg_wdata_i;
            if (wr_ptrh) ptrh_reg <= reg_wdata_i;
            if (wr_irq) ie_reg <= reg_wdata_i[FSW_B_IE];
            ctl_reg <= ctl_next;
            done_reg <= op_fin || (wr_irq ? reg_wdata_i[FSW_B_DONE]
                : done_reg);
            ind_pend_reg <= wr_ptrl || wr_ptrh || (ind_pend_reg && !ind_go);
        end
    end

    // Captured word stays until the next read or a software write
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            datl_reg <= FSW_BYTE_RST;
            dath_reg <= '0;
        end else if (cap_nvm) begin
            datl_reg <= rd_word[7:0];
            dath_reg <= rd_word[13:8];
        end else begin
            if (wr_datl) datl_reg <= reg_wdata_i;
            if (wr_dath) dath_reg <= reg_wdata_i[5:0];
        end
    end

    // Data space and the indirect registers themselves read as zero
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ind_reg <= FSW_BYTE_RST;
        end else if (cap_ind) begin
            ind_reg <= ptr_pfm ? flash_rdata_i[7:0] : 8'h00;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fetch_valid_o <= 1'b0;
            fetch_word_o <= FSW_NOP;
            done_irq_o <= 1'b0;
        end else begin
            fetch_valid_o <= cap_fet;
            if (cap_fet) begin
                fetch_word_o <= illegal ? FSW_NOP : flash_rdata_i;
            end
            done_irq_o <= done_reg && ie_reg;
        end
    end

    fsw_latches #(
        .WORDS(ROW_WORDS),
        .WIDTH(WORD_W)
    ) u_latches (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .load_i(lat_go),
        .idx_i(adrl_reg[4:0]),
        .data_i({dath_reg, datl_reg}),
        .blank_i(op_fin && !op_erase_reg),
        .bus_o(flash_wdata_o)
    );

    // ------------------------------------------------------------
    // Read-back
    // ------------------------------------------------------------
    always_comb begin
        unique case (reg_addr_i)
            FSW_OFS_ADRL: rd_mux = adrl_reg;
            FSW_OFS_ADRH: rd_mux = adrh_reg;
            FSW_OFS_DATL: rd_mux = datl_reg;
            FSW_OFS_DATH: rd_mux = {2'b00, dath_reg};
            FSW_OFS_CTL: rd_mux = {1'b0, ctl_reg};
            FSW_OFS_IRQ: rd_mux = {6'h00, ie_reg, done_reg};
            FSW_OFS_PTRL: rd_mux = ptrl_reg;
            FSW_OFS_PTRH: rd_mux = ptrh_reg;
            FSW_OFS_IND: rd_mux = ind_reg;
            default: rd_mux = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= reg_rd_i ? rd_mux : 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    AST_RD_WORD: assert property (
        (st_reg == S_REQ && kind_reg == K_NVM) |-> ##1 cap_nvm
        ##1 (!ctl_reg[FSW_B_RD] && !cpu_stall_o
        && {dath_reg, datl_reg} == $past(rd_word)))
        else $error("read word not captured");
    AST_STALL_OP: assert property (
        (st_reg == S_OP && !flash_done_i) |=> (cpu_stall_o
        && st_reg == S_OP)) else $error("CPU runs during operation");
    AST_IND_BYTE: assert property (
        cap_ind |=> ind_reg == ($past(ptr_pfm)
        ? $past(flash_rdata_i[7:0]) : 8'h00))
        else $error("indirect byte wrong");
    AST_IND_STORE: assert property (
        (wr_ind && !cap_ind) |=> $stable(ind_reg)
        && !flash_req_o.prog) else $error("indirect store acted");
    AST_PROT: assert property (
        wr_blk |=> (!ctl_reg[FSW_B_WR] && ctl_reg[FSW_B_ERR]
        && !flash_req_o.erase && !flash_req_o.prog))
        else $error("protected operation not blocked");
    AST_UNLOCK: assert property (
        $rose(ctl_reg[FSW_B_WR]) |-> $past(unl_ok && ctl_reg[FSW_B_EN]))
        else $error("write bit set without unlock");
    AST_BROKEN: assert property (
        (unl_broken && !ctl_reg[FSW_B_WR]) |=> (ctl_reg[FSW_B_ERR]
        && !ctl_reg[FSW_B_WR])) else $error("broken unlock acted");
    AST_DONE: assert property (
        op_fin |=> done_reg && !ctl_reg[FSW_B_WR] ##1 (done_irq_o
        == $past(ie_reg))) else $error("completion not flagged");
    AST_BLANK: assert property (
        (op_fin && !op_erase_reg) |=> flash_wdata_o == '1)
        else $error("latches not blank after program");
    AST_ERASE_KEEP: assert property (
        (op_fin && op_erase_reg) |=> ($stable(flash_wdata_o)
        && $stable(ctl_reg[FSW_B_EN]))) else $error("erase hit latches");
    AST_ROW: assert property (
        (flash_req_o.erase || flash_req_o.prog) |->
        flash_req_o.addr[4:0] == 5'h00) else $error("row not aligned");
    AST_LATCH: assert property (
        lat_go |=> (!flash_req_o.erase && !flash_req_o.prog
        && st_reg == S_IDLE)) else $error("latch load touched array");
    AST_NOP: assert property (
        (cap_fet && illegal) |=> (fetch_valid_o
        && fetch_word_o == FSW_NOP)) else $error("bad word not NOP");

endmodule : fsw_ctrl

// ---- src/fsw_latches.sv ----
// Row write latches of the flash self-write controller
`timescale 1ns/1ps
module fsw_latches
    import fsw_pkg::*;
#(
    parameter int WORDS = FSW_ROW_WORDS,
    parameter int WIDTH = FSW_WORD_W,
    parameter int IDX_W = $clog2(WORDS)
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic load_i,
    input wire logic [IDX_W-1:0] idx_i,
    input wire logic [WIDTH-1:0] data_i,
    input wire logic blank_i,
    output logic [WORDS*WIDTH-1:0] bus_o
);

    if (WORDS < 2 || WIDTH < 1 || (1 << IDX_W) != WORDS) begin : g_chk
        $error("fsw_latches: WORDS must be a power of two");
    end

    logic [WIDTH-1:0] mem_reg [WORDS];

    // Blank clears every word at once; erased cells read all ones
    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_reg[i] <= {WIDTH{1'b1}};
            end
        end else if (blank_i) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_reg[i] <= {WIDTH{1'b1}};
            end
        end else if (load_i) begin
            mem_reg[idx_i] <= data_i;
        end
    end

    for (genvar g = 0; g < WORDS; g++) begin : g_bus
        assign bus_o[g*WIDTH +: WIDTH] = mem_reg[g];
    end

endmodule : fsw_latches

// ---- src/fsw_pkg.sv ----
// Package: constants and carrier types of the flash self-write controller
package fsw_pkg;

    // ------------------------------------------------------------
    // Array geometry
    // ------------------------------------------------------------
    localparam int FSW_WORD_W = 14;
    localparam int FSW_ROW_WORDS = 32;
    localparam int FSW_IDX_W = 5;
    localparam logic [13:0] FSW_BLANK = 14'h3FFF;
    localparam logic [13:0] FSW_NOP = 14'h0000;
    // Reserved opcode group, fetched as a no-operation
    localparam logic [13:0] FSW_RSVD_MASK = 14'h3FF0;
    localparam logic [13:0] FSW_RSVD_VAL = 14'h0010;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] FSW_OFS_ADRL = 4'h0;
    localparam logic [3:0] FSW_OFS_ADRH = 4'h1;
    localparam logic [3:0] FSW_OFS_DATL = 4'h2;
    localparam logic [3:0] FSW_OFS_DATH = 4'h3;
    localparam logic [3:0] FSW_OFS_CTL = 4'h4;
    localparam logic [3:0] FSW_OFS_KEY = 4'h5;
    localparam logic [3:0] FSW_OFS_IRQ = 4'h6;
    localparam logic [3:0] FSW_OFS_PTRL = 4'h7;
    localparam logic [3:0] FSW_OFS_PTRH = 4'h8;
    localparam logic [3:0] FSW_OFS_IND = 4'h9;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int FSW_B_RD = 0;
    localparam int FSW_B_WR = 1;
    localparam int FSW_B_EN = 2;
    localparam int FSW_B_ERR = 3;
    localparam int FSW_B_FREE = 4;
    localparam int FSW_B_LATCH_ONLY_MODE = 5;
    localparam int FSW_B_REGS = 6;
    localparam logic [6:0] FSW_CTL_SOFT = 7'h74;
    localparam logic [6:0] FSW_CTL_RST = 7'h00;
    localparam int FSW_B_DONE = 0;
    localparam int FSW_B_IE = 1;
    localparam int FSW_B_PFM = 7;
    localparam logic [7:0] FSW_BYTE_RST = 8'h00;
    localparam logic [7:0] FSW_KEY1 = 8'h55;
    localparam logic [7:0] FSW_KEY2 = 8'hAA;

    // ------------------------------------------------------------
    // Configuration space windows
    // ------------------------------------------------------------
    localparam logic [14:0] FSW_UID_HI = 15'h0003;
    localparam logic [14:0] FSW_DID_LO = 15'h0005;
    localparam logic [14:0] FSW_CFG_LO = 15'h0007;
    localparam logic [14:0] FSW_CFG_HI = 15'h000B;
    localparam logic [14:0] FSW_DIA_LO = 15'h0100;
    localparam logic [14:0] FSW_DIA_HI = 15'h02FF;

    // Request toward the flash array
    typedef struct packed {
        logic rd;
        logic erase;
        logic prog;
        logic cfg;
        logic [14:0] addr;
    } fsw_flash_req_t;

endpackage : fsw_pkg

// ---- src/fsw_unlock.sv ----
// Unlock key sequence tracker of the flash self-write controller
`timescale 1ns/1ps
module fsw_unlock
    import fsw_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic key_wr_i,
    input wire logic [7:0] key_data_i,
    input wire logic any_acc_i,
    input wire logic start_i,
    input wire logic disturb_i,
    output logic ok_o,
    output logic broken_o
);

    typedef enum logic [1:0] {U_IDLE, U_KEY1, U_KEY2} fsw_ustate_t;

    fsw_ustate_t st_reg;
    fsw_ustate_t st_next;

    wire key1 = key_wr_i && key_data_i == FSW_KEY1;
    wire key2 = key_wr_i && key_data_i == FSW_KEY2;

    assign ok_o = st_reg == U_KEY2 && start_i && !disturb_i;
    assign broken_o = st_reg != U_IDLE && disturb_i;

    // Any other bus access between the steps voids the sequence
    always_comb begin
        st_next = st_reg;
        if (disturb_i) begin
            st_next = U_IDLE;
        end else if (key1) begin
            st_next = U_KEY1;
        end else if (key2 && st_reg == U_KEY1) begin
            st_next = U_KEY2;
        end else if (any_acc_i) begin
            st_next = U_IDLE;
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_reg <= U_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : fsw_unlock
